/* File: ioc_consts.svh */
// Purpose: Constants for the I/O input conditioning block
// Assumes: 100 MHz i_mclk, 16-bit register port, byte offsets as addresses
// Notes:   Offsets, fields, reset values and timing counts live here only
//
// Behaviour
// - Twelve channels, each usable as filtered input
// - Unfiltered: raw state sampled once per cycle
// - Filter runs on 200 us local tick
// - Level changes shorter than delay are ignored
// - Delay in 100 us units, clamp 250
// - Rising edges latched at 200 us resolution
// - Latch is reset-dominant set-reset flip-flop
// - One analog channel: ramp limiter then filter
// - Analog filter only when cycle exceeds 400 us
// - Active filter samples on 1 ms tick
// - Ramp limiting applied before filter stage
// - new = old - old/L + in/L, L=2^code
// - Filtered value converges over several updates
// - Ramp limit only with filter; step +/- limit
// - Ramp codes 1..7 give 0x3fff down to 0x00ff
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IOC_CLK_PERIOD_NS 10
`define IOC_DTICK_NS 200000
`define IOC_ATICK_NS 1000000
`define IOC_DTICK_CYC (`IOC_DTICK_NS / `IOC_CLK_PERIOD_NS)
`define IOC_ATICK_CYC (`IOC_ATICK_NS / `IOC_CLK_PERIOD_NS)
`define IOC_MIN_CYCLE_US 16'h0190
`define IOC_DELAY_MAX 8'hfa

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define IOC_OFS_DIN_LO 6'h00
`define IOC_OFS_DIN_HI 6'h01
`define IOC_OFS_AIN 6'h06
`define IOC_OFS_MASK_LO 6'h10
`define IOC_OFS_MASK_HI 6'h11
`define IOC_OFS_DFILT 6'h12
`define IOC_OFS_AFILT 6'h16
`define IOC_OFS_LATCH_LO 6'h1a
`define IOC_OFS_LATCH_HI 6'h1b
`define IOC_OFS_ACK_LO 6'h1c
`define IOC_OFS_ACK_HI 6'h1d
`define IOC_OFS_CYCLE 6'h20

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define IOC_AF_LVL_LSB 0
`define IOC_AF_LVL_MSB 2
`define IOC_AF_RAMP_LSB 4
`define IOC_AF_RAMP_MSB 6
`define IOC_RAMP_BASE 16'h7fff
`define IOC_MASK_RST 12'h000
`define IOC_DFILT_RST 8'h00
`define IOC_AFILT_RST 8'h00
`define IOC_CYCLE_RST 16'h0000

`endif

/* File: ioc_pkg.sv */
// Purpose: Shared types of the I/O input conditioning block
// Assumes: Constants come from ioc_consts.svh
// Notes:   Types only
package ioc_pkg;
	typedef logic [15:0] ioc_word_t;
	typedef logic [5:0] ioc_addr_t;
	typedef logic [7:0] ioc_delay_t;
	typedef logic [11:0] ioc_chan_t;
endpackage

/* File: ioc_din_chan.sv */
// Purpose: One digital input channel: debounce filter and edge latch
// Assumes: i_level already synchronised, i_tick one cycle every 200 us
// Notes:   Delay setting arrives clamped
`timescale 1ns/10ps
`include "ioc_consts.svh"
module ioc_din_chan (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic i_level,
	input wire logic i_enable,
	input wire ioc_pkg::ioc_delay_t i_delay,
	input wire logic i_ack,
	input wire logic i_snap,
	output logic o_state,
	output logic o_latch
);
	logic filt_q;
	logic filt_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic state_q;
	logic latch_q;
	wire lvl = i_level & i_enable;
	wire bypass = (i_delay == 8'h00);
	// Ticks needed; odd settings round up since sampling is 200 us
	wire [7:0] need = 8'((9'(i_delay) + 9'h001) >> 1);
	wire differs = (lvl != filt_q);
	wire done = ((cnt_q + 8'h01) >= need);
	// Short pulses never reach the filtered state
	assign filt_d = !i_tick ? filt_q : (bypass || (differs && done)) ? lvl : filt_q;
	assign cnt_d = !i_tick ? cnt_q : (bypass || !differs || done) ? 8'h00 : cnt_q + 8'h01;
	// Rising edge seen only at tick resolution
	wire rise = i_tick & filt_d & ~filt_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			filt_q <= 1'b0;
			cnt_q <= 8'h00;
			state_q <= 1'b0;
			latch_q <= 1'b0;
		end else begin
			filt_q <= filt_d;
			cnt_q <= cnt_d;
			// Acknowledge wins over a coincident edge
			latch_q <= ~i_ack & (latch_q | rise);
			// Snapshot at the fixed offset; raw when unfiltered
			if (i_snap) begin
				state_q <= bypass ? lvl : filt_q;
			end
		end
	end

	assign o_state = state_q;
	assign o_latch = latch_q;
endmodule

/* File: ioc_top.sv */
// Purpose: Input conditioning for twelve digital and one analog channel
// Assumes: i_net_sync and ADC signals are on i_mclk; i_din are pins
// Notes:   Register port: read data valid only in the cycle after i_rd
`timescale 1ns/10ps
`include "ioc_consts.svh"
module ioc_top #(
	parameter int unsigned P_DTICK_CYC = `IOC_DTICK_CYC,
	parameter int unsigned P_ATICK_CYC = `IOC_ATICK_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire ioc_pkg::ioc_chan_t i_din,
	input wire logic i_net_sync,
	input wire ioc_pkg::ioc_word_t i_adc_data,
	input wire logic i_adc_valid,
	input wire ioc_pkg::ioc_addr_t i_addr,
	input wire ioc_pkg::ioc_word_t i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output ioc_pkg::ioc_word_t o_rd_data,
	output ioc_pkg::ioc_chan_t o_din_state,
	output ioc_pkg::ioc_chan_t o_din_latch,
	output ioc_pkg::ioc_word_t o_ain_value
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	ioc_pkg::ioc_chan_t sync1_q;
	ioc_pkg::ioc_chan_t sync2_q;
	ioc_pkg::ioc_chan_t sync3_q;
	ioc_pkg::ioc_chan_t pin_q;
	// A bit changes only once stages two and three agree
	wire [11:0] pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1_q <= 12'h000;
			sync2_q <= 12'h000;
			sync3_q <= 12'h000;
			pin_q <= 12'h000;
		end else begin
			sync1_q <= i_din;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q <= pin_d;
		end
	end

	// ------------------------------------------------------------
	// Local timebases
	// ------------------------------------------------------------
	// Free running, so they drift against the network cycle by design
	logic [16:0] dcnt_q;
	logic [16:0] acnt_q;
	wire dtick = (dcnt_q == 17'(P_DTICK_CYC - 1));
	wire atick = (acnt_q == 17'(P_ATICK_CYC - 1));

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			dcnt_q <= 17'h00000;
			acnt_q <= 17'h00000;
		end else begin
			dcnt_q <= dtick ? 17'h00000 : dcnt_q + 17'h00001;
			acnt_q <= atick ? 17'h00000 : acnt_q + 17'h00001;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	ioc_pkg::ioc_chan_t mask_q;
	ioc_pkg::ioc_delay_t dfilt_q;
	logic [7:0] afilt_q;
	ioc_pkg::ioc_chan_t ack_q;
	ioc_pkg::ioc_word_t cycle_q;
	wire wr_mask_lo = i_wr && (i_addr == `IOC_OFS_MASK_LO);
	wire wr_mask_hi = i_wr && (i_addr == `IOC_OFS_MASK_HI);
	wire wr_dfilt = i_wr && (i_addr == `IOC_OFS_DFILT);
	wire wr_afilt = i_wr && (i_addr == `IOC_OFS_AFILT);
	wire wr_ack_lo = i_wr && (i_addr == `IOC_OFS_ACK_LO);
	wire wr_ack_hi = i_wr && (i_addr == `IOC_OFS_ACK_HI);
	wire wr_cycle = i_wr && (i_addr == `IOC_OFS_CYCLE);
	wire [7:0] wr_byte = i_wr_data[7:0];
	// Oversized delay settings are held at the maximum
	wire [7:0] delay_clamped = (wr_byte > `IOC_DELAY_MAX) ? `IOC_DELAY_MAX : wr_byte;
	// Analog state must restart from the raw value on a new setting
	wire afilt_chg = wr_afilt && (wr_byte != afilt_q);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mask_q <= `IOC_MASK_RST;
			dfilt_q <= `IOC_DFILT_RST;
			afilt_q <= `IOC_AFILT_RST;
			ack_q <= 12'h000;
			cycle_q <= `IOC_CYCLE_RST;
		end else begin
			if (wr_mask_lo) begin
				mask_q[7:0] <= wr_byte;
			end
			if (wr_mask_hi) begin
				mask_q[11:8] <= wr_byte[3:0];
			end
			if (wr_dfilt) begin
				dfilt_q <= delay_clamped;
			end
			if (wr_afilt) begin
				afilt_q <= wr_byte;
			end
			if (wr_ack_lo) begin
				ack_q[7:0] <= wr_byte;
			end
			if (wr_ack_hi) begin
				ack_q[11:8] <= wr_byte[3:0];
			end
			if (wr_cycle) begin
				cycle_q <= i_wr_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Digital channels
	// ------------------------------------------------------------
	ioc_pkg::ioc_chan_t din_state;
	ioc_pkg::ioc_chan_t din_latch;

	// Mask bit set means the channel is used as an output
	for (genvar g = 0; g < 12; g++) begin : g_chan
		ioc_din_chan u_chan (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.i_tick(dtick),
			.i_level(pin_q[g]),
			.i_enable(~mask_q[g]),
			.i_delay(dfilt_q),
			.i_ack(ack_q[g]),
			.i_snap(i_net_sync),
			.o_state(din_state[g]),
			.o_latch(din_latch[g])
		);
	end

	// ------------------------------------------------------------
	// Analog path
	// ------------------------------------------------------------
	ioc_pkg::ioc_word_t adc_q;
	ioc_pkg::ioc_word_t trk_q;
	ioc_pkg::ioc_word_t val_q;
	ioc_pkg::ioc_word_t ain_q;
	wire [2:0] lvl_code = afilt_q[`IOC_AF_LVL_MSB:`IOC_AF_LVL_LSB];
	wire [2:0] ramp_code = afilt_q[`IOC_AF_RAMP_MSB:`IOC_AF_RAMP_LSB];
	// Filter only for long enough network cycles
	wire flt_on = (lvl_code != 3'h0) && (cycle_q > `IOC_MIN_CYCLE_US);
	// Limit halves per code, 0x3fff at code 1 to 0x00ff at 7
	wire [15:0] lim = (ramp_code == 3'h0) ? 16'h0000 : (`IOC_RAMP_BASE >> ramp_code);
	wire signed [16:0] diff = $signed({adc_q[15], adc_q}) - $signed({trk_q[15], trk_q});
	wire signed [16:0] lim_s = $signed({1'b0, lim});
	// Step clamped to exactly plus or minus the limit
	wire [15:0] trk_new = (lim == 16'h0000) ? adc_q :
		(diff > lim_s) ? trk_q + lim :
		(diff < -lim_s) ? trk_q - lim : adc_q;
	// Shift by the level code: L = 2 to 128
	wire signed [16:0] old_s = $signed({val_q[15], val_q});
	wire signed [16:0] new_s = $signed({trk_new[15], trk_new});
	wire signed [16:0] step = old_s - (old_s >>> lvl_code) + (new_s >>> lvl_code);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			adc_q <= 16'h0000;
			trk_q <= 16'h0000;
			val_q <= 16'h0000;
			ain_q <= 16'h0000;
		end else begin
			if (i_adc_valid) begin
				adc_q <= i_adc_data;
			end
			if (afilt_chg) begin
				// New setting starts from the raw sample
				trk_q <= adc_q;
				val_q <= adc_q;
			end else if (!flt_on) begin
				// Bypass passes raw conversions straight through
				trk_q <= adc_q;
				val_q <= adc_q;
			end else if (atick) begin
				// 1 ms timebase; limiter output feeds the filter
				trk_q <= trk_new;
				// Moves by a fraction per step, never a full jump
				val_q <= 16'(step);
			end
			if (i_net_sync) begin
				ain_q <= val_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	ioc_pkg::ioc_word_t rd_q;
	wire [15:0] rd_mux =
		(i_addr == `IOC_OFS_DIN_LO) ? {8'h00, din_state[7:0]} :
		(i_addr == `IOC_OFS_DIN_HI) ? {12'h000, din_state[11:8]} :
		(i_addr == `IOC_OFS_AIN) ? ain_q :
		(i_addr == `IOC_OFS_MASK_LO) ? {8'h00, mask_q[7:0]} :
		(i_addr == `IOC_OFS_MASK_HI) ? {12'h000, mask_q[11:8]} :
		(i_addr == `IOC_OFS_DFILT) ? {8'h00, dfilt_q} :
		(i_addr == `IOC_OFS_AFILT) ? {8'h00, afilt_q} :
		(i_addr == `IOC_OFS_LATCH_LO) ? {8'h00, din_latch[7:0]} :
		(i_addr == `IOC_OFS_LATCH_HI) ? {12'h000, din_latch[11:8]} :
		(i_addr == `IOC_OFS_ACK_LO) ? {8'h00, ack_q[7:0]} :
		(i_addr == `IOC_OFS_ACK_HI) ? {12'h000, ack_q[11:8]} :
		(i_addr == `IOC_OFS_CYCLE) ? cycle_q : 16'h0000;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rd_q <= 16'h0000;
		end else begin
			rd_q <= i_rd ? rd_mux : 16'h0000;
		end
	end

	assign o_rd_data = rd_q;
	assign o_din_state = din_state;
	assign o_din_latch = din_latch;
	assign o_ain_value = ain_q;
endmodule

/* File: ioc_sensor_model.sv */
// Purpose: Field sensor model: twelve switch pins and one converter
// Assumes: Converter result is valid only in its one-cycle pulse
// Notes:   i_gap 0 converts every cycle, larger values answer slowly
`timescale 1ns/10ps
module ioc_sensor_model (
	input wire logic i_mclk,
	input wire logic [11:0] i_level,
	input wire logic [15:0] i_target,
	input wire logic [2:0] i_gap,
	output logic [11:0] o_din = 12'h000,
	output logic [15:0] o_adc_data = 16'h0000,
	output logic o_adc_valid = 1'b0
);
	logic [2:0] cnt_q = 3'h0;
	always_ff @(posedge i_mclk) begin
		o_din <= i_level;
		cnt_q <= (cnt_q >= i_gap) ? 3'h0 : cnt_q + 3'h1;
		o_adc_valid <= (cnt_q == 3'h0);
		// Between pulses the bus toggles, so a stale result is never mistaken for data
		o_adc_data <= (cnt_q == 3'h0) ? i_target : ~o_adc_data;
	end
endmodule

/* File: ioc_top_chk.sv */
// Purpose: Port-level assertions for the input conditioning block
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Pin-to-latch bound only watches channel 0
`timescale 1ns/10ps
`include "ioc_consts.svh"
module ioc_top_chk #(
	parameter int unsigned P_DTICK_CYC = `IOC_DTICK_CYC,
	parameter int unsigned P_ATICK_CYC = `IOC_ATICK_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire ioc_pkg::ioc_chan_t i_din,
	input wire logic i_net_sync,
	input wire ioc_pkg::ioc_word_t i_adc_data,
	input wire logic i_adc_valid,
	input wire ioc_pkg::ioc_addr_t i_addr,
	input wire ioc_pkg::ioc_word_t i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire ioc_pkg::ioc_word_t o_rd_data,
	input wire ioc_pkg::ioc_chan_t o_din_state,
	input wire ioc_pkg::ioc_chan_t o_din_latch,
	input wire ioc_pkg::ioc_word_t o_ain_value
);
	logic [3:0] low_q;
	// Held at the top in reset so no unknown age reaches the latch check
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			low_q <= 4'hf;
		end else begin
			low_q <= i_din[0] ? 4'h0 : ((low_q == 4'hf) ? low_q : low_q + 4'h1);
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	state_hold_a: assert property (!i_net_sync |=> $stable(o_din_state))
		else $error("input state moved without a sync strobe");
	ain_hold_a: assert property (!i_net_sync |=> $stable(o_ain_value))
		else $error("analog value moved without a sync strobe");
	ack_clear_a: assert property ((i_wr && i_addr == `IOC_OFS_ACK_LO) |->
		##2 (o_din_latch[7:0] & $past(i_wr_data[7:0], 2)) == 8'h00) else $error("acknowledged latch still set");
	latch_cause_a: assert property ($rose(o_din_latch[0]) |-> low_q < 4'hc)
		else $error("latch set without a recent high pin");
	delay_clamp_a: assert property ((i_wr && i_addr == `IOC_OFS_DFILT && i_wr_data[7:0] > `IOC_DELAY_MAX)
		##1 !i_wr ##1 (i_rd && i_addr == `IOC_OFS_DFILT) |=> o_rd_data[7:0] == `IOC_DELAY_MAX) else $error("delay not clamped");
	mask_back_a: assert property ((i_wr && i_addr == `IOC_OFS_MASK_LO) ##1 !i_wr
		##1 (i_rd && i_addr == `IOC_OFS_MASK_LO) |=> o_rd_data[7:0] == $past(i_wr_data[7:0], 3)) else $error("mask readback wrong");
	rd_stand_a: assert property ((i_rd ##1 !i_rd) |=> o_rd_data == 16'h0000)
		else $error("read data held past one cycle");
	unmapped_read_a: assert property ((i_rd && i_addr == 6'h3f) |=> o_rd_data == 16'h0000)
		else $error("unmapped read not zero");
	rst_out_a: assert property ($fell(i_rst) |-> (o_din_latch == 12'h000 && o_ain_value == 16'h0000))
		else $error("outputs not cleared by reset");
	cover property (i_net_sync ##1 o_din_latch != 12'h000);
	cover property ($fell(o_din_latch[0]));
	cover property (i_net_sync ##1 o_ain_value != 16'h0000);
endmodule
bind ioc_top ioc_top_chk #(.P_DTICK_CYC(P_DTICK_CYC), .P_ATICK_CYC(P_ATICK_CYC)) chk_u (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_din(i_din), .i_net_sync(i_net_sync), .i_adc_data(i_adc_data), .i_adc_valid(i_adc_valid),
	.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
	.o_din_state(o_din_state), .o_din_latch(o_din_latch), .o_ain_value(o_ain_value));

/* File: ioc_top_tb.sv */
// Purpose: Self-checking bench for the input conditioning block
// Assumes: Short tick parameters, analog tick phase follows reset release
// Notes:   Results are noted in a queue and compared by a monitor
`timescale 1ns/10ps
`include "ioc_consts.svh"
module ioc_top_tb;
	localparam int AT = 50;
	logic i_mclk = 1'b0, i_rst = 1'b1, sync = 1'b0, wr_s = 1'b0, rd_s = 1'b0, adcv, rd_p = 1'b0, sy_p = 1'b0;
	logic [11:0] lvl = 12'h000;
	logic [2:0] gap = 3'h3;
	ioc_pkg::ioc_chan_t din, st, lt;
	ioc_pkg::ioc_word_t tgt = 16'h0000, wd = 16'h0000, adc, rdd, ain;
	ioc_pkg::ioc_addr_t addr = 6'h00;
	logic [17:0] q[$];
	logic [17:0] nt;
	logic [15:0] got;
	int failures = 0, n_checks = 0, cyc = 0;
	always #5 i_mclk = ~i_mclk;
	ioc_sensor_model sns_u (.i_mclk(i_mclk), .i_level(lvl), .i_target(tgt), .i_gap(gap), .o_din(din),
		.o_adc_data(adc), .o_adc_valid(adcv));
	ioc_top #(.P_DTICK_CYC(20), .P_ATICK_CYC(AT)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_din(din),
		.i_net_sync(sync), .i_adc_data(adc), .i_adc_valid(adcv), .i_addr(addr), .i_wr_data(wd), .i_wr(wr_s),
		.i_rd(rd_s), .o_rd_data(rdd), .o_din_state(st), .o_din_latch(lt), .o_ain_value(ain));
	task automatic print_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Monitor: oldest note against the output that just settled
	// ------------------------------------------------------------
	always @(posedge i_mclk) begin
		cyc <= i_rst ? 0 : cyc + 1;
		if (rd_p || sy_p) begin
			nt = q.pop_front();
			got = (nt[17:16] == 2'h0) ? rdd : (nt[17:16] == 2'h1) ? {4'h0, st} :
				(nt[17:16] == 2'h2) ? {4'h0, lt} : ain;
			n_checks++;
			if (got !== nt[15:0]) begin
				failures++;
				$display("FAIL t=%0t sel=%h exp=%h got=%h", $time, nt[17:16], nt[15:0], got);
			end
		end
		rd_p <= rd_s;
		sy_p <= sync;
	end
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge i_mclk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		q.push_back({2'h0, e});
		@(posedge i_mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge i_mclk);
		rd_s <= 1'b0;
	endtask
	task automatic snap(input logic [1:0] s, input logic [15:0] e);
		q.push_back({s, e});
		@(posedge i_mclk);
		sync <= 1'b1;
		@(posedge i_mclk);
		sync <= 1'b0;
		@(posedge i_mclk);
	endtask
	initial begin
		#300000;
		failures++;
		print_verdict();
	end
	initial begin
		int k;
		logic [31:0] r;
		logic [15:0] c;
		logic [15:0] e;
		r = $urandom(32'h0d5b5a24);
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(`IOC_OFS_DFILT, 16'h0000);
		rd(`IOC_OFS_AFILT, 16'h0000);
		rd(`IOC_OFS_CYCLE, 16'h0000);
		wr(6'h3f, 16'hffff);
		rd(6'h3f, 16'h0000);
		wr(`IOC_OFS_MASK_LO, 16'h005a);
		rd(`IOC_OFS_MASK_LO, 16'h005a);
		wr(`IOC_OFS_MASK_LO, 16'h0000);
		wr(`IOC_OFS_DFILT, 16'h00fb);
		rd(`IOC_OFS_DFILT, 16'h00fa);
		$display("register test done");
		wr(`IOC_OFS_DFILT, 16'h0000);
		r = $urandom;
		lvl <= r[11:0];
		repeat (50) @(posedge i_mclk);
		snap(2'h1, {4'h0, r[11:0]});
		snap(2'h2, {4'h0, r[11:0]});
		rd(`IOC_OFS_LATCH_LO, {8'h00, r[7:0]});
		rd(`IOC_OFS_LATCH_HI, {12'h000, r[11:8]});
		rd(`IOC_OFS_DIN_HI, {12'h000, r[11:8]});
		wr(`IOC_OFS_ACK_LO, 16'h00ff);
		wr(`IOC_OFS_ACK_HI, 16'h000f);
		rd(`IOC_OFS_ACK_HI, 16'h000f);
		lvl <= 12'h000;
		repeat (50) @(posedge i_mclk);
		lvl <= 12'hfff;
		repeat (50) @(posedge i_mclk);
		snap(2'h2, 16'h0000);
		wr(`IOC_OFS_ACK_LO, 16'h0000);
		wr(`IOC_OFS_ACK_HI, 16'h0000);
		repeat (50) @(posedge i_mclk);
		snap(2'h2, 16'h0000);
		$display("raw and latch test done");
		wr(`IOC_OFS_DFILT, 16'h0006);
		lvl <= 12'h000;
		repeat (100) @(posedge i_mclk);
		lvl <= 12'h001;
		repeat (25) @(posedge i_mclk);
		lvl <= 12'h000;
		repeat (100) @(posedge i_mclk);
		snap(2'h1, 16'h0000);
		lvl <= 12'h001;
		repeat (100) @(posedge i_mclk);
		snap(2'h1, 16'h0001);
		snap(2'h2, 16'h0001);
		wr(`IOC_OFS_MASK_LO, 16'h0001);
		repeat (100) @(posedge i_mclk);
		snap(2'h1, 16'h0000);
		rd(`IOC_OFS_DIN_LO, 16'h0000);
		wr(`IOC_OFS_MASK_LO, 16'h0000);
		$display("debounce test done");
		wr(`IOC_OFS_CYCLE, 16'h0190);
		wr(`IOC_OFS_AFILT, 16'h0077);
		tgt <= r[31:16];
		repeat (10) @(posedge i_mclk);
		snap(2'h3, r[31:16]);
		wr(`IOC_OFS_CYCLE, 16'h03e8);
		for (k = 1; k < 15; k++) begin
			gap <= k[0] ? 3'h0 : 3'h4;
			tgt <= 16'h0000;
			repeat (10) @(posedge i_mclk);
			c = (k < 8) ? 16'(k) : 16'((k - 7) * 16 + 1);
			wr(`IOC_OFS_AFILT, c);
			repeat (AT) begin
				if ((cyc % AT) != 20) @(posedge i_mclk);
			end
			if ((cyc % AT) != 20) begin
				failures++;
				print_verdict();
			end
			tgt <= 16'h7fff;
			repeat (AT) @(posedge i_mclk);
			e = (k < 8) ? (16'h7fff >> k) : (16'h7fff >> (k - 6));
			snap(2'h3, e);
			rd(`IOC_OFS_AIN, e);
		end
		$display("analog test done");
		print_verdict();
	end
endmodule
